//--- atcal_conv_model.sv
// Purpose: behavioural converter that answers each start with one code
// Assumes: one start at a time, answer after delay_in plus one cycles
// Notes: outside the done pulse the data lines show the inverse of the last code
module atcal_conv_model (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic start_in,
	input wire logic [7:0] delay_in,
	input wire logic [15:0] code_in,
	output logic done_out,
	output logic [15:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] count;
	logic busy;
	logic [15:0] last;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count <= 8'h00;
			busy <= 1'b0;
			done_out <= 1'b0;
			last <= 16'h0000;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				busy <= 1'b1;
				count <= delay_in;
			end else if (busy && count != 8'h00) begin
				count <= count - 8'h01;
			end else if (busy) begin
				busy <= 1'b0;
				done_out <= 1'b1;
				last <= code_in;
			end
		end
	end
	// Stale code must never look valid to the block
	assign data_out = done_out ? last : ~last;
endmodule // atcal_conv_model

//--- atcal_defines.svh
// Purpose: register offsets, field positions and reset values of the converter control block
// Assumes: byte addresses are the low 12 bits of the printed register addresses
// Notes: definitions only
`ifndef ATCAL_DEFINES_SVH
`define ATCAL_DEFINES_SVH
`define ATCAL_AW 12
`define ATCAL_OFS_FRONT_END_CONTROL 12'h000
`define ATCAL_OFS_POWER_MODE 12'h004
`define ATCAL_OFS_OUTPUT_FILTER_CONFIG 12'h044
`define ATCAL_OFS_RAW_RESULT 12'h074
`define ATCAL_OFS_SECOND_FILTER_RESULT 12'h080
`define ATCAL_OFS_PRIMARY_SENSOR_RESULT 12'h084
`define ATCAL_OFS_CONVERTER_IRQ_ENABLE 12'h088
`define ATCAL_OFS_CONVERTER_IRQ_STATUS 12'h098
`define ATCAL_OFS_PRIMARY_SENSOR_CONTROL 12'h174
`define ATCAL_OFS_CONVERTER_CONFIG 12'h1A8
`define ATCAL_OFS_BACKUP_SENSOR_SWITCH 12'h374
`define ATCAL_OFS_INPUT_BUFFER_CONFIG 12'h38C
`define ATCAL_OFS_OFFSET_TRIM_HIGHSPEED 12'h234
`define ATCAL_OFS_GAIN_TRIM_SENSOR 12'h238
`define ATCAL_OFS_OFFSET_TRIM_SENSOR 12'h23C
`define ATCAL_OFS_GAIN_TRIM_GAIN_ONE 12'h240
`define ATCAL_OFS_OFFSET_TRIM_GAIN_ONE 12'h244
`define ATCAL_OFS_GAIN_TRIM_GAIN_ONE_HALF 12'h270
`define ATCAL_OFS_GAIN_TRIM_GAIN_TWO 12'h274
`define ATCAL_OFS_GAIN_TRIM_GAIN_FOUR 12'h278
`define ATCAL_OFS_GAIN_TRIM_HIGHSPEED 12'h284
`define ATCAL_OFS_OFFSET_TRIM_LOWPOWER_A 12'h288
`define ATCAL_OFS_GAIN_TRIM_LOWPOWER_A 12'h28C
`define ATCAL_OFS_GAIN_TRIM_GAIN_NINE 12'h298
`define ATCAL_OFS_OFFSET_TRIM_LOWPOWER_B 12'h2C0
`define ATCAL_OFS_GAIN_TRIM_LOWPOWER_B 12'h2C4
`define ATCAL_OFS_OFFSET_TRIM_GAIN_TWO 12'h2C8
`define ATCAL_OFS_OFFSET_TRIM_GAIN_ONE_HALF 12'h2CC
`define ATCAL_OFS_OFFSET_TRIM_GAIN_NINE 12'h2D0
`define ATCAL_OFS_OFFSET_TRIM_GAIN_FOUR 12'h2D4
`define ATCAL_BIT_POWER_UP 7
`define ATCAL_BIT_CONVERT 8
`define ATCAL_BIT_SENSOR_POWER 12
`define ATCAL_BIT_SENSOR_CONVERT 13
`define ATCAL_BIT_SECOND_FILTER 16
`define ATCAL_BIT_HIGH_POWER 0
`define ATCAL_BIT_STA_RESULT 0
`define ATCAL_BIT_STA_SENSOR 1
`define ATCAL_POS_LSB 0
`define ATCAL_NEG_LSB 8
`define ATCAL_GAIN_LSB 16
`define ATCAL_CHOP_LSB 1
`define ATCAL_POS_SENSOR 6'h0B
`define ATCAL_NEG_SENSOR 5'h0B
`define ATCAL_NEG_JUNCTION_REF 5'h15
`define ATCAL_GAIN_CODE_1 3'h0
`define ATCAL_GAIN_CODE_1P5 3'h1
`define ATCAL_GAIN_CODE_2 3'h2
`define ATCAL_GAIN_CODE_4 3'h3
`define ATCAL_GAIN_CODE_9 3'h4
`define ATCAL_RST_GAIN_TRIM 32'h00004000
`define ATCAL_RST_OFFSET_TRIM 32'h00000000
`define ATCAL_RST_FILTER 32'h00000301
`define ATCAL_RST_SWITCH 32'h00020000
`define ATCAL_RST_BUFFER 32'h005F3D00
`define ATCAL_TRIM_SENSOR 8
`define ATCAL_TRIM_LP_A 5
`define ATCAL_TRIM_LP_B 6
`define ATCAL_TRIM_HS 7
`endif

//--- atcal_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: nothing beyond the defines header
// Notes: numbers live in atcal_defines.svh
package atcal_pkg;
	typedef enum logic [2:0] {
		ATCAL_IDLE = 3'h1,
		ATCAL_BUSY = 3'h2,
		ATCAL_STAGE2 = 3'h4
	} atcal_state_t;
	typedef struct packed {
		logic power_up;
		logic sensor_power;
		logic [2:0] chop;
		logic [5:0] pos_sel;
		logic [4:0] neg_sel;
		logic [2:0] gain;
		logic [15:0] switches;
		logic [31:0] buffer_cfg;
		logic high_power;
	} atcal_analog_t;
	typedef struct packed {
		logic [5:0] pos_sel;
		logic [2:0] gain;
		logic high_power;
		logic sensor_conv;
		logic second_filter;
	} atcal_snap_t;
endpackage

//--- atcal_tb.sv
// Purpose: self-checking bench of the converter control block
// Assumes: converter model answers every start about ten cycles later
// Notes: trims stay below 0x8000 so their sign never matters
`include "atcal_defines.svh"
module testbench import atcal_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_CTL = `ATCAL_OFS_FRONT_END_CONTROL;
	localparam logic [11:0] A_CFG = `ATCAL_OFS_CONVERTER_CONFIG;
	localparam logic [11:0] A_RAW = `ATCAL_OFS_RAW_RESULT;
	localparam logic [11:0] A_SEC = `ATCAL_OFS_SECOND_FILTER_RESULT;
	localparam logic [11:0] A_STA = `ATCAL_OFS_CONVERTER_IRQ_STATUS;
	localparam logic [11:0] A_IEN = `ATCAL_OFS_CONVERTER_IRQ_ENABLE;
	localparam logic [11:0] GAIN_A [5] = '{12'h240, 12'h270, 12'h274, 12'h278, 12'h298};
	localparam logic [11:0] OFF_A [5] = '{12'h244, 12'h2CC, 12'h2C8, 12'h2D4, 12'h2D0};
	localparam logic [11:0] COFF_A [3] = '{12'h288, 12'h2C0, 12'h234};
	localparam logic [31:0] CTL_V = 32'h00000180;
	localparam logic [31:0] CTL_S = 32'h00003180;
	localparam logic [31:0] CTL_F = 32'h00010180;
	logic clk_in, nrst_in, wr_in, rd_in, conv_done_in, conv_start_out, irq_out;
	logic [11:0] addr_in;
	logic [31:0] wdata_in, rdata_out;
	logic [15:0] conv_data_in, mcode, sw;
	atcal_analog_t analog_out;
	int errors, tests_run;
	atcal_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .conv_done_in(conv_done_in),
		.conv_data_in(conv_data_in), .conv_start_out(conv_start_out),
		.analog_out(analog_out), .irq_out(irq_out));
	atcal_conv_model conv_m (.clk_in(clk_in), .nrst_in(nrst_in), .start_in(conv_start_out),
		.delay_in(8'h0A), .code_in(mcode), .done_out(conv_done_in), .data_out(conv_data_in));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Signed (raw - offset) * gain / 0x4000, clipped to 16 bits
	function automatic logic [31:0] corr(input logic [15:0] raw, off, gn);
		logic signed [35:0] p;
		p = $signed(raw);
		p = p - $signed(off);
		p = p * $signed({1'b0, gn});
		p = p >>> 14;
		if (p > 36'sd32767) return 32'h00007FFF;
		if (p < -36'sd32768) return 32'hFFFF8000;
		return {{16{p[15]}}, p[15:0]};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(rdata_out, exp);
	endtask
	task automatic conv(input logic [31:0] ctl, input logic [15:0] code, input logic mid,
		input logic [31:0] midcfg);
		int n;
		mcode <= code;
		wr(A_CTL, ctl);
		chk(32'(conv_start_out), 32'h1);
		if (mid) wr(A_CFG, midcfg);
		n = 0;
		while (conv_done_in !== 1'b1 && n < 40) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk(32'(n < 40), 32'h1);
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rd_chk(GAIN_A[i], 32'h00004000);
			rd_chk(OFF_A[i], 32'h0);
		end
		rd_chk(`ATCAL_OFS_GAIN_TRIM_SENSOR, 32'h00004000);
		rd_chk(`ATCAL_OFS_OFFSET_TRIM_SENSOR, 32'h0);
		rd_chk(`ATCAL_OFS_GAIN_TRIM_GAIN_ONE_HALF, 32'h00004000);
		rd_chk(12'hFF0, 32'h0);
		chk(32'(analog_out.buffer_cfg), 32'h005F3D00);
		chk(32'(analog_out.switches), 32'h0);
	endtask
	// Start-up in the order software must follow
	task automatic t_init();
		wr(A_CTL, 32'h00000080);
		chk(32'(analog_out.power_up), 32'h1);
		wr(`ATCAL_OFS_INPUT_BUFFER_CONFIG, 32'h005F3D04);
		chk(analog_out.buffer_cfg, 32'h005F3D04);
		wr(A_CFG, 32'h00010000);
		chk(32'(analog_out.gain), 32'h1);
		wr(`ATCAL_OFS_OUTPUT_FILTER_CONFIG, 32'h00000301);
		wr(A_CTL, 32'h00010080);
		wr(A_CFG, 32'hFFFFFFFF);
		rd_chk(A_CFG, 32'h00071F3F);
		wr(A_CFG, 32'h00010B0B);
		chk(32'(analog_out.pos_sel), 32'h0B);
		chk(32'(analog_out.neg_sel), 32'h0B);
	endtask
	task automatic t_sensor();
		wr(`ATCAL_OFS_PRIMARY_SENSOR_CONTROL, 32'h2);
		chk(32'(analog_out.chop), 32'h1);
		chk(32'(analog_out.sensor_power), 32'h0);
		wr(`ATCAL_OFS_OFFSET_TRIM_SENSOR, 32'h10);
		wr(`ATCAL_OFS_GAIN_TRIM_SENSOR, 32'h6000);
		wr(A_IEN, 32'h2);
		wr(A_CTL, 32'h00002080);
		chk(32'(conv_start_out), 32'h0);
		// Two conversions, as chopping needs an even count
		for (int k = 0; k < 2; k++) begin
			conv(CTL_S, 16'h0100 + 16'(k * 64), 1'b0, 32'h0);
			chk(32'(analog_out.sensor_power), 32'h1);
			rd_chk(`ATCAL_OFS_PRIMARY_SENSOR_RESULT, corr(16'h0100 + 16'(k * 64), 16'h10, 16'h6000));
			rd_chk(A_RAW, corr(16'h0100 + 16'(k * 64), 16'h10, 16'h6000));
		end
		chk(32'(irq_out), 32'h1);
		wr(A_STA, 32'h3);
		@(posedge clk_in);
		#1;
		chk(32'(irq_out), 32'h0);
		wr(A_IEN, 32'h0);
		conv(CTL_S, 16'h0080, 1'b0, 32'h0);
		chk(32'(irq_out), 32'h0);
		rd_chk(A_STA, 32'h3);
		wr(A_STA, 32'h3);
		wr(A_CTL, 32'h00000080);
		chk(32'(analog_out.sensor_power), 32'h0);
	endtask
	task automatic t_gains();
		for (int i = 0; i < 5; i++) begin
			wr(OFF_A[i], 32'(16 * (i + 1)));
			wr(GAIN_A[i], 32'h4000 + 32'(i * 2048));
			wr(A_CFG, {13'h0, 3'(i), 16'h0801});
			chk(32'(analog_out.gain), 32'(i));
			conv(CTL_V, 16'h0400, 1'b0, 32'h0);
			rd_chk(A_RAW, corr(16'h0400, 16'(16 * (i + 1)), 16'h4000 + 16'(i * 2048)));
		end
		conv(CTL_V, 16'h7FF0, 1'b0, 32'h0);
		rd_chk(A_RAW, corr(16'h7FF0, 16'h50, 16'h6000));
		wr(A_CFG, 32'h00000801);
		// Gain moved mid-conversion must not swap the trims in use
		conv(CTL_V, 16'h0400, 1'b1, 32'h00040801);
		rd_chk(A_RAW, corr(16'h0400, 16'h10, 16'h4000));
		chk(32'(analog_out.gain), 32'h4);
	endtask
	task automatic t_current();
		for (int j = 0; j < 3; j++) wr(COFF_A[j], 32'(32 + 16 * j));
		for (int p = 0; p < 2; p++) begin
			wr(`ATCAL_OFS_POWER_MODE, 32'(p));
			chk(32'(analog_out.high_power), 32'(p));
			wr(A_CFG, 32'h00000801);
			wr(OFF_A[0], 32'h10);
			for (int j = 0; j < 3; j++) begin
				wr(A_CFG, 32'h00000821 + 32'(j));
				conv(CTL_V, 16'h0300, 1'b0, 32'h0);
				rd_chk(A_RAW, 32'h02F0 - ((p == 1 && j == 1) ? 32'h0 : 32'(32 + 16 * j)));
			end
		end
		wr(`ATCAL_OFS_POWER_MODE, 32'h0);
		// Unity second stage must leave the first-stage result alone
		wr(COFF_A[2], 32'h0);
		wr(A_CFG, 32'h00000823);
		conv(CTL_V, 16'h0300, 1'b0, 32'h0);
		rd_chk(A_RAW, 32'h000002F0);
	endtask
	// Full backup-sensor sweep: 16 single, 4 groups, all switches
	task automatic t_backup();
		wr(A_CFG, 32'h0000150B);
		chk(32'(analog_out.neg_sel), 32'h15);
		chk(32'(analog_out.pos_sel), 32'h0B);
		for (int i = 0; i < 21; i++) begin
			sw = (i < 16) ? 16'h1 << i : ((i < 20) ? 16'hF << (4 * (i - 16)) : 16'hFFFF);
			wr(`ATCAL_OFS_BACKUP_SENSOR_SWITCH, {16'h0, sw});
			chk(32'(analog_out.switches), 32'(sw));
			conv((i % 2) ? CTL_F : CTL_V, 16'h0200 + 16'(i), 1'b0, 32'h0);
			rd_chk((i % 2) ? A_SEC : A_RAW, corr(16'h0200 + 16'(i), 16'h10, 16'h6000));
		end
	endtask
	initial begin
		errors = 0;
		tests_run = 0;
		nrst_in = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 12'h000;
		wdata_in = 32'h0;
		mcode = 16'h0000;
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_init();
		t_sensor();
		t_gains();
		t_current();
		t_backup();
		close_out();
	end
	// Whole run is about a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		errors++;
		close_out();
	end
endmodule // testbench

//--- atcal_top.sv
// Purpose: converter control, channel select and automatic offset/gain correction
// Assumes: converter returns one 16-bit raw code per start, pulsing done_in
// Notes: corrected result lands two cycles after done_in
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "atcal_defines.svh"
module atcal_top #(
	parameter int DW = 16,
	parameter logic [5:0] POS_LOWPOWER_A = 6'h21,
	parameter logic [5:0] POS_LOWPOWER_B = 6'h22,
	parameter logic [5:0] POS_HIGHSPEED = 6'h23
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [`ATCAL_AW-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic conv_done_in,
	input wire logic [15:0] conv_data_in,
	output logic conv_start_out,
	output atcal_pkg::atcal_analog_t analog_out,
	output logic irq_out
);
	import atcal_pkg::*;

	if (DW != 16) begin : g_dw_check
		$error("atcal_top supports DW = 16 only");
	end

	logic [31:0] front_end_control;
	logic [31:0] power_mode;
	logic [31:0] output_filter_config;
	logic [31:0] converter_config;
	logic [31:0] primary_sensor_control;
	logic [31:0] backup_sensor_switch_control;
	logic [31:0] input_buffer_config;
	logic [31:0] converter_irq_enable;
	logic [31:0] irq_status;
	logic [31:0] raw_result;
	logic [31:0] second_filter_result;
	logic [31:0] primary_sensor_result;
	logic [31:0] offset_trim [0:8];
	logic [31:0] gain_trim [0:8];
	atcal_state_t state;
	atcal_snap_t snap;
	logic signed [15:0] stage1;
	logic signed [15:0] next_final;
	logic start_ok;
	logic wr_front;
	logic [4:0] trim_idx;
	logic trim_is_gain;
	logic trim_hit;
	logic done_now;
	logic final_now;

	// Saturating correction: (raw - offset) * gain / 0x4000
	function automatic logic signed [15:0] correct(input logic signed [15:0] raw,
			input logic [31:0] off, input logic [31:0] gn);
		logic signed [16:0] diff;
		logic signed [33:0] prod;
		logic signed [33:0] shf;
		diff = $signed({raw[15], raw}) - $signed({off[15], off[15:0]});
		prod = $signed({{17{diff[16]}}, diff}) * $signed({18'h00000, gn[15:0]});
		shf = prod >>> 14;
		if (shf > 34'sh00007FFF) begin
			correct = 16'sh7FFF;
		end else if (shf < -34'sh00008000) begin
			correct = 16'sh8000;
		end else begin
			correct = shf[15:0];
		end
	endfunction

	// Gain code to voltage-trim index
	function automatic logic [3:0] gain_index(input logic [2:0] code);
		case (code)
			`ATCAL_GAIN_CODE_1: gain_index = 4'h0;
			`ATCAL_GAIN_CODE_1P5: gain_index = 4'h1;
			`ATCAL_GAIN_CODE_2: gain_index = 4'h2;
			`ATCAL_GAIN_CODE_4: gain_index = 4'h3;
			`ATCAL_GAIN_CODE_9: gain_index = 4'h4;
			default: gain_index = 4'h0;
		endcase
	endfunction

	// Trim address decode; index bit 4 marks a gain trim
	always_comb begin
		trim_hit = 1'b1;
		trim_idx = 5'h00;
		case (addr_in)
			`ATCAL_OFS_OFFSET_TRIM_GAIN_ONE: trim_idx = 5'h00;
			`ATCAL_OFS_OFFSET_TRIM_GAIN_ONE_HALF: trim_idx = 5'h01;
			`ATCAL_OFS_OFFSET_TRIM_GAIN_TWO: trim_idx = 5'h02;
			`ATCAL_OFS_OFFSET_TRIM_GAIN_FOUR: trim_idx = 5'h03;
			`ATCAL_OFS_OFFSET_TRIM_GAIN_NINE: trim_idx = 5'h04;
			`ATCAL_OFS_OFFSET_TRIM_LOWPOWER_A: trim_idx = 5'h05;
			`ATCAL_OFS_OFFSET_TRIM_LOWPOWER_B: trim_idx = 5'h06;
			`ATCAL_OFS_OFFSET_TRIM_HIGHSPEED: trim_idx = 5'h07;
			`ATCAL_OFS_OFFSET_TRIM_SENSOR: trim_idx = 5'h08;
			`ATCAL_OFS_GAIN_TRIM_GAIN_ONE: trim_idx = 5'h10;
			`ATCAL_OFS_GAIN_TRIM_GAIN_ONE_HALF: trim_idx = 5'h11;
			`ATCAL_OFS_GAIN_TRIM_GAIN_TWO: trim_idx = 5'h12;
			`ATCAL_OFS_GAIN_TRIM_GAIN_FOUR: trim_idx = 5'h13;
			`ATCAL_OFS_GAIN_TRIM_GAIN_NINE: trim_idx = 5'h14;
			`ATCAL_OFS_GAIN_TRIM_LOWPOWER_A: trim_idx = 5'h15;
			`ATCAL_OFS_GAIN_TRIM_LOWPOWER_B: trim_idx = 5'h16;
			`ATCAL_OFS_GAIN_TRIM_HIGHSPEED: trim_idx = 5'h17;
			`ATCAL_OFS_GAIN_TRIM_SENSOR: trim_idx = 5'h18;
			default: trim_hit = 1'b0;
		endcase
	end
	assign trim_is_gain = trim_idx[4];

	// Control registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			front_end_control <= 32'h00000000;
			power_mode <= 32'h00000000;
			output_filter_config <= `ATCAL_RST_FILTER;
			converter_config <= 32'h00000000;
			primary_sensor_control <= 32'h00000000;
			backup_sensor_switch_control <= `ATCAL_RST_SWITCH;
			input_buffer_config <= `ATCAL_RST_BUFFER;
			converter_irq_enable <= 32'h00000000;
		end else if (wr_in) begin
			case (addr_in)
				`ATCAL_OFS_FRONT_END_CONTROL: front_end_control <= wdata_in;
				`ATCAL_OFS_POWER_MODE: power_mode <= wdata_in;
				`ATCAL_OFS_OUTPUT_FILTER_CONFIG: output_filter_config <= wdata_in;
				`ATCAL_OFS_CONVERTER_CONFIG: converter_config <= wdata_in & 32'h0007_1F3F;
				`ATCAL_OFS_PRIMARY_SENSOR_CONTROL: primary_sensor_control <= wdata_in;
				`ATCAL_OFS_BACKUP_SENSOR_SWITCH: backup_sensor_switch_control <= wdata_in;
				`ATCAL_OFS_INPUT_BUFFER_CONFIG: input_buffer_config <= wdata_in;
				`ATCAL_OFS_CONVERTER_IRQ_ENABLE: converter_irq_enable <= wdata_in;
				default: ;
			endcase
		end
	end

	// Trim registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 9; i++) begin
				offset_trim[i] <= `ATCAL_RST_OFFSET_TRIM;
				gain_trim[i] <= `ATCAL_RST_GAIN_TRIM;
			end
		end else if (wr_in && trim_hit) begin
			if (trim_is_gain) begin
				gain_trim[trim_idx[3:0]] <= wdata_in;
			end else begin
				offset_trim[trim_idx[3:0]] <= wdata_in;
			end
		end
	end

	// Analog-side drives, all straight from control registers
	assign analog_out.power_up = front_end_control[`ATCAL_BIT_POWER_UP];
	assign analog_out.sensor_power = front_end_control[`ATCAL_BIT_SENSOR_POWER];
	assign analog_out.chop = primary_sensor_control[`ATCAL_CHOP_LSB +: 3];
	// Codes pass unchanged: 001011/01011 and 10101 route the sensors
	assign analog_out.pos_sel = converter_config[`ATCAL_POS_LSB +: 6];
	assign analog_out.neg_sel = converter_config[`ATCAL_NEG_LSB +: 5];
	assign analog_out.gain = converter_config[`ATCAL_GAIN_LSB +: 3];
	assign analog_out.switches = backup_sensor_switch_control[15:0];
	assign analog_out.buffer_cfg = input_buffer_config;
	assign analog_out.high_power = power_mode[`ATCAL_BIT_HIGH_POWER];

	assign wr_front = wr_in && (addr_in == `ATCAL_OFS_FRONT_END_CONTROL);
	assign start_ok = wr_front && wdata_in[`ATCAL_BIT_CONVERT] && wdata_in[`ATCAL_BIT_POWER_UP]
		&& (state == ATCAL_IDLE);
	assign done_now = (state == ATCAL_BUSY) && conv_done_in;
	assign final_now = (state == ATCAL_STAGE2);

	// Sequencer; settings frozen at start so a mid-conversion edit cannot mix trims
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= ATCAL_IDLE;
			conv_start_out <= 1'b0;
			snap <= '0;
		end else begin
			conv_start_out <= start_ok;
			case (state)
				ATCAL_IDLE: begin
					if (start_ok) begin
						state <= ATCAL_BUSY;
						snap.pos_sel <= converter_config[`ATCAL_POS_LSB +: 6];
						snap.gain <= converter_config[`ATCAL_GAIN_LSB +: 3];
						snap.high_power <= power_mode[`ATCAL_BIT_HIGH_POWER];
						snap.sensor_conv <= wdata_in[`ATCAL_BIT_SENSOR_CONVERT];
						snap.second_filter <= wdata_in[`ATCAL_BIT_SECOND_FILTER];
					end
				end
				ATCAL_BUSY: begin
					if (conv_done_in) begin
						state <= ATCAL_STAGE2;
					end
				end
				ATCAL_STAGE2: state <= ATCAL_IDLE;
				default: state <= ATCAL_IDLE;
			endcase
		end
	end

	// First stage: sensor trims or gain-indexed voltage trims
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stage1 <= 16'sh0000;
		end else if (done_now) begin
			if (snap.pos_sel == `ATCAL_POS_SENSOR) begin
				stage1 <= correct($signed(conv_data_in), offset_trim[`ATCAL_TRIM_SENSOR],
					gain_trim[`ATCAL_TRIM_SENSOR]);
			end else begin
				stage1 <= correct($signed(conv_data_in), offset_trim[gain_index(snap.gain)],
					gain_trim[gain_index(snap.gain)]);
			end
		end
	end

	// Second stage for current channels; channel B skipped in high power
	always_comb begin
		if (snap.pos_sel == POS_LOWPOWER_A) begin
			next_final = correct(stage1, offset_trim[`ATCAL_TRIM_LP_A],
				gain_trim[`ATCAL_TRIM_LP_A]);
		end else if (snap.pos_sel == POS_LOWPOWER_B && !snap.high_power) begin
			next_final = correct(stage1, offset_trim[`ATCAL_TRIM_LP_B],
				gain_trim[`ATCAL_TRIM_LP_B]);
		end else if (snap.pos_sel == POS_HIGHSPEED) begin
			next_final = correct(stage1, offset_trim[`ATCAL_TRIM_HS],
				gain_trim[`ATCAL_TRIM_HS]);
		end else begin
			next_final = stage1;
		end
	end

	// Result registers, sign-extended to the word
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			raw_result <= 32'h00000000;
			second_filter_result <= 32'h00000000;
			primary_sensor_result <= 32'h00000000;
		end else if (final_now) begin
			if (snap.second_filter) begin
				second_filter_result <= {{16{next_final[15]}}, next_final};
			end else begin
				raw_result <= {{16{next_final[15]}}, next_final};
			end
			if (snap.sensor_conv) begin
				primary_sensor_result <= {{16{next_final[15]}}, next_final};
			end
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_status <= 32'h00000000;
		end else begin
			if (wr_in && addr_in == `ATCAL_OFS_CONVERTER_IRQ_STATUS) begin
				irq_status <= irq_status & ~wdata_in;
			end
			if (final_now) begin
				irq_status[`ATCAL_BIT_STA_RESULT] <= 1'b1;
				irq_status[`ATCAL_BIT_STA_SENSOR] <= snap.sensor_conv
					|| (irq_status[`ATCAL_BIT_STA_SENSOR] && !(wr_in
					&& addr_in == `ATCAL_OFS_CONVERTER_IRQ_STATUS
					&& wdata_in[`ATCAL_BIT_STA_SENSOR]));
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_status & converter_irq_enable);
		end
	end

	// Read port: data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 32'h00000000;
		end else if (!rd_in) begin
			rdata_out <= 32'h00000000;
		end else if (trim_hit) begin
			rdata_out <= trim_is_gain ? gain_trim[trim_idx[3:0]] : offset_trim[trim_idx[3:0]];
		end else begin
			case (addr_in)
				`ATCAL_OFS_FRONT_END_CONTROL: rdata_out <= front_end_control;
				`ATCAL_OFS_POWER_MODE: rdata_out <= power_mode;
				`ATCAL_OFS_OUTPUT_FILTER_CONFIG: rdata_out <= output_filter_config;
				`ATCAL_OFS_RAW_RESULT: rdata_out <= raw_result;
				`ATCAL_OFS_SECOND_FILTER_RESULT: rdata_out <= second_filter_result;
				`ATCAL_OFS_PRIMARY_SENSOR_RESULT: rdata_out <= primary_sensor_result;
				`ATCAL_OFS_CONVERTER_IRQ_ENABLE: rdata_out <= converter_irq_enable;
				`ATCAL_OFS_CONVERTER_IRQ_STATUS: rdata_out <= irq_status;
				`ATCAL_OFS_PRIMARY_SENSOR_CONTROL: rdata_out <= primary_sensor_control;
				`ATCAL_OFS_CONVERTER_CONFIG: rdata_out <= converter_config;
				`ATCAL_OFS_BACKUP_SENSOR_SWITCH: rdata_out <= backup_sensor_switch_control;
				`ATCAL_OFS_INPUT_BUFFER_CONFIG: rdata_out <= input_buffer_config;
				default: rdata_out <= 32'h00000000;
			endcase
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_done;
		done_now;
	endsequence
	sequence s_result_flag;
		##2 irq_status[`ATCAL_BIT_STA_RESULT];
	endsequence

	AST_START_PULSE: assert property (start_ok |=> conv_start_out ##1 !conv_start_out)
		else $error("start pulse missing or too long");
	AST_SENSOR_POWER: assert property ($rose(analog_out.sensor_power)
		|-> $past(wr_front && wdata_in[`ATCAL_BIT_SENSOR_POWER]))
		else $error("sensor powered without a control write");
	AST_SENSOR_TRIM: assert property (done_now && snap.pos_sel == `ATCAL_POS_SENSOR
		|=> stage1 == correct($signed($past(conv_data_in)), offset_trim[`ATCAL_TRIM_SENSOR],
		gain_trim[`ATCAL_TRIM_SENSOR]))
		else $error("sensor trims not applied");
	AST_ROUTE: assert property (final_now && snap.second_filter
		|=> second_filter_result[15:0] == $past(next_final) && $stable(raw_result))
		else $error("result routed to wrong register");
	AST_RESULT_FLAG: assert property (s_done |-> s_result_flag)
		else $error("result flag not set two cycles after done");
	AST_IRQ_GATE: assert property (irq_out |-> $past(|(irq_status & converter_irq_enable)))
		else $error("interrupt raised without an enabled source");
	AST_LP_B_HIGH: assert property (final_now && snap.pos_sel == POS_LOWPOWER_B
		&& snap.high_power |-> next_final == stage1)
		else $error("channel B trims used in high power");
	AST_SNAP_HOLD: assert property (state != ATCAL_IDLE |=> $stable(snap))
		else $error("settings snapshot changed mid conversion");
	AST_UNITY: assert property (final_now && snap.pos_sel == POS_HIGHSPEED
		&& offset_trim[`ATCAL_TRIM_HS] == 32'h00000000
		&& gain_trim[`ATCAL_TRIM_HS] == `ATCAL_RST_GAIN_TRIM |-> next_final == stage1)
		else $error("unity trims changed the result");
endmodule // atcal_top
